/* File: sdt_trig_detect.sv */
// Trigger detector: noise filter, channel conditions, phase sequencing and register port.
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "sdt_map.svh"

module sdt_filter #(
  parameter int AW = 24
) (
  // Clock and reset
  input  wire logic          core_clk_i,
  input  wire logic          rst_i,
  // Control
  input  wire logic          clr_i,
  input  wire logic          step_i,
  input  wire logic          cond_i,
  input  wire logic          rt_i,
  input  wire logic          rt_on_i,
  input  wire logic [2:0]    sel_i,
  input  wire logic [AW-1:0] ivl_us_i,
  // Result
  output logic               pass_o
);
  localparam logic [9:0] FTAB [8] = `SDT_FTAB;
  localparam logic [AW:0] RT_US = (AW+1)'(`SDT_RT_FILT_MS * `SDT_US_PER_MS);
  localparam logic [10:0] RT_MIN = 11'(`SDT_RT_MIN_SMP);
  logic [9:0]    cnt_r;
  logic [9:0]    cnt_nxt;
  logic [AW-1:0] acc_r;
  logic [AW-1:0] acc_nxt;
  wire [10:0]    cnt_inc = {1'b0, cnt_r} + 11'h001;
  wire [AW:0]    acc_sum = {1'b0, acc_r} + {1'b0, ivl_us_i};
  wire [9:0]     need = FTAB[sel_i];
  wire           drop_cnt = clr_i || (step_i && !cond_i);
  wire           hs_ok = (sel_i == `SDT_FS_OFF) || ({1'b0, need} <= cnt_inc); // [RL8] [RL9]
  wire           long_ivl = {1'b0, ivl_us_i} >= RT_US;
  // A long recording interval falls back to a count of samples.
  wire           rt_ok = !rt_on_i || (acc_sum >= RT_US
                         && (!long_ivl || cnt_inc >= RT_MIN)); // [RL10] [RL11]

  assign pass_o = cond_i && (rt_i ? rt_ok : hs_ok);
  assign cnt_nxt = drop_cnt ? '0 : (step_i && !(&cnt_r)) ? cnt_inc[9:0] : cnt_r; // [RL22]
  assign acc_nxt = drop_cnt ? '0 : !step_i ? acc_r :
                   acc_sum[AW] ? '1 : acc_sum[AW-1:0];

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= '0;
      acc_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
      acc_r <= acc_nxt;
    end
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  a_filt_restart: assert property (step_i && !cond_i |=> cnt_r == '0) // [RL22]
    else $error("filter count not restarted after a failing sample");
  a_filt_ten_samples: assert property (
    pass_o && !rt_i && sel_i == 3'h1 |-> cnt_r >= 10'h009) // [RL9]
    else $error("ten-sample filter passed early");
  a_rt_two_samples: assert property (
    pass_o && rt_i && rt_on_i && long_ivl |-> cnt_r != '0) // [RL11]
    else $error("real-time filter passed on a single long sample");
endmodule

// Summary of operation
// [RL1] Pre-trigger fill first, then wait for trigger.
// [RL2] Triggers ignored during pre-trigger fill.
// [RL3] Edge mode rising slope: fire crossing upward.
// [RL4] Edge mode falling slope: fire crossing downward.
// [RL5] All mode: above for high, below for low.
// [RL6] In-window fires on entering the band.
// [RL7] Out-of-window fires on leaving the band.
// [RL8] Filter: condition must hold whole filter period.
// [RL9] Ten-sample filter needs ten consecutive hits.
// [RL10] Real-time filter on means ten milliseconds.
// [RL11] Real-time interval of 10 ms: two samples.
// [RL12] Drop fires: peak below level half cycle.
// [RL13] Drop and judgment: high-speed, instantaneous only.
// [RL14] Drop half-cycle uses 50 or 60 Hz.
// [RL15] Drop level clamped to range/10..range*10.
// [RL16] Judgment fires when leaving the judgment range.
// [RL17] Real-time stop timing uses own stop condition.
// [RL18] Triggers on hidden channels stay active.
// [RL19] Edge mode fires on unmet-to-met change only.
// [RL20] All mode fires whenever all conditions met.
// [RL21] Stop ignored for max(1 ms, two samples).
// [RL22] Filter count restarts; evaluate once per sample.
module sdt_trig_detect #(
  parameter int NCH = 4,
  parameter int SW = 16,
  parameter int AW = 24,
  parameter int HCW = 20,
  parameter int SAMPLE_HZ = 1000000,
  parameter int DEAD_CYC = `SDT_DEAD_MS * `SDT_NS_PER_MS / `SDT_CLK_NS
) (
  // Clock and reset
  input  wire logic            core_clk_i,
  input  wire logic            rst_i,
  // Register port
  input  wire logic [5:0]      reg_addr_i,
  input  wire logic [31:0]     reg_wdata_i,
  input  wire logic            reg_wr_i,
  input  wire logic            reg_rd_i,
  output logic [31:0]          reg_rdata_o,
  // Sample stream
  input  wire logic            smp_valid_i,
  input  wire logic [NCH*SW-1:0] smp_data_i,
  // Acquisition control
  input  wire logic            meas_start_i,
  output var sdt_pkg::sdt_evt_t trig_o,
  output logic                 pre_wait_o,
  output logic                 trig_wait_o
);
  localparam int DCW = $clog2(DEAD_CYC + 1);
  localparam logic [HCW-1:0] H50 = HCW'(SAMPLE_HZ / (`SDT_HALF_DIV * `SDT_HZ50));
  localparam logic [HCW-1:0] H60 = HCW'(SAMPLE_HZ / (`SDT_HALF_DIV * `SDT_HZ60));
  localparam logic [DCW-1:0] DEAD_N = DCW'(DEAD_CYC);
  localparam logic [1:0] DEAD_S = 2'(`SDT_DEAD_SMP);

  logic [31:0]            ctrl_r;
  logic [31:0]            pre_r;
  logic [AW-1:0]          ivl_r;
  logic [31:0]            pre_cnt_r;
  logic [DCW-1:0]         dcyc_r;
  logic [1:0]             dsmp_r;
  logic                   seen_s_r;
  logic                   seen_p_r;
  sdt_pkg::sdt_state_t    state_r;
  sdt_pkg::sdt_state_t    state_nxt;
  sdt_pkg::sdt_timing_t   tim;
  sdt_pkg::sdt_evt_t      trig_nxt;
  logic [NCH-1:0]         act_s;
  logic [NCH-1:0]         met_s;
  logic [NCH-1:0]         rise_s;
  logic [NCH-1:0]         act_p;
  logic [NCH-1:0]         met_p;
  logic [NCH-1:0]         rise_p;
  logic [NCH-1:0][31:0]   ch_rd;
  logic [31:0]            rd_val;

  function automatic logic lvl_met(input logic signed [SW-1:0] v, input logic signed [SW-1:0] l,
                                   input logic fall, input logic andm);
    lvl_met = andm ? (fall ? v < l : v > l) : (fall ? v <= l : v >= l);
  endfunction

  // Sample strobe, restart and control word fields.
  wire       step = smp_valid_i;
  wire       clr = meas_start_i;
  wire       en = ctrl_r[`SDT_C_EN];
  wire       rt = ctrl_r[`SDT_C_RT];
  wire       and_m = ctrl_r[`SDT_C_AND];
  wire       f50 = ctrl_r[`SDT_C_F50];
  wire [2:0] fsel = ctrl_r[`SDT_C_FSEL];
  wire       rtf = ctrl_r[`SDT_C_RTF];
  wire [HCW-1:0] half = f50 ? H50 : H60; // [RL14]
  // High-speed operation has no stop timing.
  assign tim = rt ? sdt_pkg::sdt_timing_t'(ctrl_r[`SDT_C_TIM]) : sdt_pkg::SDT_TM_START;

  // Global register decode.
  wire wr_ctrl = reg_wr_i && reg_addr_i == `SDT_A_CTRL;
  wire wr_pre = reg_wr_i && reg_addr_i == `SDT_A_PRE;
  wire wr_ivl = reg_wr_i && reg_addr_i == `SDT_A_IVL;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_r <= `SDT_CTRL_RST;
      pre_r <= '0;
      ivl_r <= '0;
    end else begin
      if (wr_ctrl) ctrl_r <= reg_wdata_i;
      if (wr_pre) pre_r <= reg_wdata_i;
      if (wr_ivl) ivl_r <= reg_wdata_i[AW-1:0];
    end
  end

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic [8:0]     cfg_r;
    logic [SW-1:0]  lvl_r;
    logic [SW-1:0]  up_r;
    logic [SW-1:0]  lo_r;
    logic [SW-1:0]  slvl_r;
    logic [SW-1:0]  vrng_r;
    logic [HCW-1:0] dcnt_r;
    logic           prev_s_r;
    logic           prev_p_r;
    logic           s_f;
    logic           p_f;
    sdt_pkg::sdt_type_t ttype;
    sdt_pkg::sdt_type_t ptype;
    sdt_pkg::sdt_type_t st;
    sdt_pkg::sdt_type_t sp;

    wire hit = reg_wr_i && reg_addr_i[5:3] == 3'(c) + `SDT_CH_BASE;
    wire [2:0] off = reg_addr_i[2:0];

    always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
        cfg_r <= `SDT_CFG_RST;
        lvl_r <= '0;
        up_r <= '0;
        lo_r <= '0;
        slvl_r <= '0;
        vrng_r <= '0;
      end else if (hit) begin
        if (off == `SDT_O_CFG) cfg_r <= reg_wdata_i[8:0];
        if (off == `SDT_O_LVL) lvl_r <= reg_wdata_i[SW-1:0];
        if (off == `SDT_O_UP) up_r <= reg_wdata_i[SW-1:0];
        if (off == `SDT_O_LO) lo_r <= reg_wdata_i[SW-1:0];
        if (off == `SDT_O_SLVL) slvl_r <= reg_wdata_i[SW-1:0];
        if (off == `SDT_O_VRNG) vrng_r <= reg_wdata_i[SW-1:0];
      end
    end

    assign ch_rd[c] = off == `SDT_O_CFG ? 32'(cfg_r) : off == `SDT_O_LVL ? 32'(lvl_r) :
                      off == `SDT_O_UP ? 32'(up_r) : off == `SDT_O_LO ? 32'(lo_r) :
                      off == `SDT_O_SLVL ? 32'(slvl_r) : off == `SDT_O_VRNG ? 32'(vrng_r) : '0;

    // Display or recording switches do not reach this logic, so hidden channels still trigger.
    wire signed [SW-1:0] x = $signed(smp_data_i[c*SW +: SW]); // [RL18]
    wire in_band = x <= $signed(up_r) && x >= $signed(lo_r);
    wire inst_ok = !rt && cfg_r[`SDT_G_INST];
    assign ttype = sdt_pkg::sdt_type_t'(cfg_r[`SDT_G_TYPE]);
    assign ptype = sdt_pkg::sdt_type_t'(cfg_r[`SDT_G_STYPE]);
    wire hs_only = ttype == sdt_pkg::SDT_T_DROP || ttype == sdt_pkg::SDT_T_JUDGE;
    assign st = (hs_only && !inst_ok) || ttype > sdt_pkg::SDT_T_JUDGE ?
                sdt_pkg::SDT_T_OFF : ttype; // [RL13]
    // Stop conditions exist only in real-time operation, where drop and judgment are absent.
    assign sp = ptype == sdt_pkg::SDT_T_LEVEL || ptype == sdt_pkg::SDT_T_IN ||
                ptype == sdt_pkg::SDT_T_OUT ? ptype : sdt_pkg::SDT_T_OFF;

    // The drop level is an instantaneous magnitude held inside the channel range limits.
    wire [SW:0]   ax = x[SW-1] ? (SW+1)'(-{x[SW-1], x}) : {1'b0, x};
    wire [SW-1:0] vr_lo = vrng_r / SW'(`SDT_RNG_DIV);
    wire [SW+3:0] vr_hi = {4'h0, vrng_r} * (SW+4)'(`SDT_RNG_MUL);
    wire [SW-1:0] lvl_u = lvl_r[SW-1] ? '0 : lvl_r;
    wire [SW+3:0] dlvl = lvl_u < vr_lo ? {4'h0, vr_lo} :
                         {4'h0, lvl_u} > vr_hi ? vr_hi : {4'h0, lvl_u}; // [RL15]
    wire          below = {3'h0, ax} < dlvl;
    wire [HCW:0]  dinc = {1'b0, dcnt_r} + (HCW+1)'(1'b1);
    wire          drop_c = below && dinc >= {1'b0, half}; // [RL12]

    wire s_raw = st == sdt_pkg::SDT_T_LEVEL ?
                 lvl_met(x, $signed(lvl_r), cfg_r[`SDT_G_SLOPE], and_m) : // [RL3] [RL4] [RL5]
                 st == sdt_pkg::SDT_T_IN ? in_band : // [RL6]
                 st == sdt_pkg::SDT_T_OUT ? !in_band : // [RL7]
                 st == sdt_pkg::SDT_T_JUDGE ? !in_band : // [RL16]
                 st == sdt_pkg::SDT_T_DROP ? drop_c : 1'b0;
    wire p_raw = sp == sdt_pkg::SDT_T_LEVEL ?
                 lvl_met(x, $signed(slvl_r), cfg_r[`SDT_G_SSLOPE], and_m) :
                 sp == sdt_pkg::SDT_T_IN ? in_band :
                 sp == sdt_pkg::SDT_T_OUT ? !in_band : 1'b0; // [RL17]

    sdt_filter #(.AW(AW)) u_fs (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .clr_i      (clr),
      .step_i     (step),
      .cond_i     (s_raw),
      .rt_i       (rt),
      .rt_on_i    (rtf),
      .sel_i      (fsel),
      .ivl_us_i   (ivl_r),
      .pass_o     (s_f)
    );
    sdt_filter #(.AW(AW)) u_fp (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .clr_i      (clr),
      .step_i     (step),
      .cond_i     (p_raw),
      .rt_i       (rt),
      .rt_on_i    (rtf),
      .sel_i      (fsel),
      .ivl_us_i   (ivl_r),
      .pass_o     (p_f)
    );

    // Previous state starts as met, so a condition already true at start cannot make an edge.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
        dcnt_r <= '0;
        prev_s_r <= 1'b1;
        prev_p_r <= 1'b1;
      end else if (clr) begin
        dcnt_r <= '0;
        prev_s_r <= 1'b1; // [RL19]
        prev_p_r <= 1'b1;
      end else if (step) begin
        dcnt_r <= !below ? '0 : dinc[HCW] ? dcnt_r : dinc[HCW-1:0];
        prev_s_r <= s_f;
        prev_p_r <= p_f;
      end
    end

    assign act_s[c] = st != sdt_pkg::SDT_T_OFF;
    assign met_s[c] = s_f;
    assign rise_s[c] = s_f && !prev_s_r;
    assign act_p[c] = sp != sdt_pkg::SDT_T_OFF;
    assign met_p[c] = p_f;
    assign rise_p[c] = p_f && !prev_p_r;
  end

  // Source combination, evaluated once per sample.
  wire all_s = &(met_s | ~act_s); // [RL20]
  wire any_s = |(rise_s & act_s); // [RL19]
  wire all_p = &(met_p | ~act_p);
  wire any_p = |(rise_p & act_p);
  wire fire_s = step && en && |act_s && (and_m ? all_s : any_s); // [RL22]
  wire fire_p = step && en && rt && |act_p && (and_m ? all_p : any_p); // [RL17]
  wire pre_done = pre_cnt_r >= pre_r;
  wire dead_done = dcyc_r >= DEAD_N && dsmp_r >= DEAD_S; // [RL21]
  wire in_pre = state_r == sdt_pkg::SDT_S_PRE;
  wire in_dead = state_r == sdt_pkg::SDT_S_DEAD;

  always_comb begin
    state_nxt = state_r;
    if (clr) begin
      state_nxt = sdt_pkg::SDT_S_PRE; // [RL1]
    end else begin
      unique case (state_r)
        sdt_pkg::SDT_S_IDLE, sdt_pkg::SDT_S_DONE: begin
          state_nxt = state_r;
        end
        sdt_pkg::SDT_S_PRE: begin
          if (pre_done) begin
            state_nxt = tim == sdt_pkg::SDT_TM_STOP ? sdt_pkg::SDT_S_WSTOP :
                        sdt_pkg::SDT_S_WSTART; // [RL1]
          end
        end
        sdt_pkg::SDT_S_WSTART: begin
          if (fire_s) begin
            state_nxt = tim == sdt_pkg::SDT_TM_BOTH ? sdt_pkg::SDT_S_DEAD : sdt_pkg::SDT_S_DONE;
          end
        end
        sdt_pkg::SDT_S_DEAD: begin
          if (dead_done) state_nxt = sdt_pkg::SDT_S_WSTOP; // [RL21]
        end
        sdt_pkg::SDT_S_WSTOP: begin
          if (fire_p) state_nxt = sdt_pkg::SDT_S_DONE;
        end
        default: begin
          state_nxt = sdt_pkg::SDT_S_IDLE;
        end
      endcase
    end
  end

  // Triggers pass only in the waiting states, never while the pre-trigger fills.
  assign trig_nxt.start = !clr && state_r == sdt_pkg::SDT_S_WSTART && fire_s; // [RL2]
  assign trig_nxt.stop = !clr && state_r == sdt_pkg::SDT_S_WSTOP && fire_p; // [RL21]

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= sdt_pkg::SDT_S_IDLE;
      trig_o <= '0;
      pre_cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      trig_o <= trig_nxt;
      pre_cnt_r <= clr ? '0 : (in_pre && step) ? pre_cnt_r + 32'h0000_0001 : pre_cnt_r;
    end
  end

  // Dead time needs both the clock count and the sample count to expire.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dcyc_r <= '0;
      dsmp_r <= '0;
    end else begin
      dcyc_r <= !in_dead ? '0 : dcyc_r < DEAD_N ? dcyc_r + DCW'(1'b1) : dcyc_r;
      dsmp_r <= !in_dead ? '0 : (step && dsmp_r < DEAD_S) ? dsmp_r + 2'h1 : dsmp_r;
    end
  end

  // Sticky fire flags: the restart clears them and blocks any trigger in the same cycle.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      seen_s_r <= 1'b0;
      seen_p_r <= 1'b0;
    end else begin
      seen_s_r <= trig_nxt.start || (seen_s_r && !clr);
      seen_p_r <= trig_nxt.stop || (seen_p_r && !clr);
    end
  end

  // Read path: data stand only in the cycle after the read strobe.
  wire [2:0] rch = reg_addr_i[5:3] - `SDT_CH_BASE;
  wire       rch_ok = reg_addr_i[5:3] >= `SDT_CH_BASE && {1'b0, rch} < 4'(NCH);
  assign rd_val = reg_addr_i == `SDT_A_CTRL ? ctrl_r :
                  reg_addr_i == `SDT_A_PRE ? pre_r :
                  reg_addr_i == `SDT_A_IVL ? 32'(ivl_r) :
                  reg_addr_i == `SDT_A_STAT ? 32'({seen_p_r, seen_s_r, state_r}) :
                  rch_ok ? ch_rd[rch] : '0;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= '0;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_val : '0;
    end
  end

  assign pre_wait_o = in_pre;
  assign trig_wait_o = state_r == sdt_pkg::SDT_S_WSTART || state_r == sdt_pkg::SDT_S_WSTOP;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_pre_hold;
    in_pre && !clr;
  endsequence
  sequence s_dead_exit;
    in_dead ##1 state_r == sdt_pkg::SDT_S_WSTOP;
  endsequence

  a_pre_quiet: assert property (s_pre_hold |=> !trig_o.start && !trig_o.stop) // [RL2]
    else $error("trigger issued during pre-trigger fill");
  a_pre_exit_wait: assert property (
    s_pre_hold ##1 (!in_pre && !clr) |-> $past(pre_done) && trig_wait_o) // [RL1]
    else $error("pre-trigger fill left early or not into a wait phase");
  a_and_fires: assert property (
    state_r == sdt_pkg::SDT_S_WSTART && !clr && fire_s |=> trig_o.start) // [RL20]
    else $error("start trigger not issued while all conditions met");
  a_or_edge_only: assert property (
    trig_o.start && !$past(and_m) |-> $past(any_s)) // [RL19]
    else $error("edge-mode trigger without an unmet-to-met change");
  a_dead_time: assert property (s_dead_exit |-> $past(dcyc_r) >= DEAD_N
    && $past(dsmp_r) >= DEAD_S) // [RL21]
    else $error("stop phase entered before the dead time elapsed");
  a_stop_rt_only: assert property (trig_o.stop |-> $past(rt) && $past(|act_p)) // [RL17]
    else $error("stop trigger outside real-time stop timing");
endmodule
`default_nettype wire

/* File: sdt_map.svh */
// Register map, field positions, reset values and timing figures of the trigger detector.
`ifndef SDT_MAP_SVH
`define SDT_MAP_SVH
`define SDT_A_CTRL 6'h00
`define SDT_A_PRE 6'h01
`define SDT_A_IVL 6'h02
`define SDT_A_STAT 6'h03
`define SDT_CH_BASE 3'h1
`define SDT_O_CFG 3'h0
`define SDT_O_LVL 3'h1
`define SDT_O_UP 3'h2
`define SDT_O_LO 3'h3
`define SDT_O_SLVL 3'h4
`define SDT_O_VRNG 3'h5
`define SDT_C_EN 0
`define SDT_C_RT 1
`define SDT_C_AND 2
`define SDT_C_TIM 4:3
`define SDT_C_F50 5
`define SDT_C_FSEL 8:6
`define SDT_C_RTF 9
`define SDT_G_TYPE 2:0
`define SDT_G_SLOPE 3
`define SDT_G_STYPE 6:4
`define SDT_G_SSLOPE 7
`define SDT_G_INST 8
`define SDT_CTRL_RST 32'h0000_0000
`define SDT_CFG_RST 9'h000
`define SDT_FS_OFF 3'h0
`define SDT_FTAB '{10'h000, 10'h00A, 10'h014, 10'h032, 10'h064, 10'h0C8, 10'h1F4, 10'h3E8}
`define SDT_CLK_NS 4
`define SDT_NS_PER_MS 1000000
`define SDT_US_PER_MS 1000
`define SDT_DEAD_MS 1
`define SDT_DEAD_SMP 2
`define SDT_RT_FILT_MS 10
`define SDT_RT_MIN_SMP 2
`define SDT_HZ50 50
`define SDT_HZ60 60
`define SDT_HALF_DIV 2
`define SDT_RNG_DIV 10
`define SDT_RNG_MUL 10
`endif

/* File: sdt_pkg.sv */
// Types shared by the trigger detector.
package sdt_pkg;
  typedef enum logic [2:0] {
    SDT_T_OFF, SDT_T_LEVEL, SDT_T_IN, SDT_T_OUT, SDT_T_DROP, SDT_T_JUDGE
  } sdt_type_t;
  typedef enum logic [1:0] {SDT_TM_START, SDT_TM_STOP, SDT_TM_BOTH} sdt_timing_t;
  typedef enum logic [2:0] {
    SDT_S_IDLE, SDT_S_PRE, SDT_S_WSTART, SDT_S_DEAD, SDT_S_WSTOP, SDT_S_DONE
  } sdt_state_t;
  typedef struct packed {
    logic start;
    logic stop;
  } sdt_evt_t;
endpackage

/* File: sdt_smp_src.sv */
// Model of the digitized sample stream that feeds the trigger detector.
`timescale 1ns/100ps
`default_nettype none
module sdt_smp_src #(
  parameter int NCH = 4,
  parameter int SW  = 16
) (
  // Clock
  input  wire logic           core_clk_i,
  // Sample stream
  output logic                smp_valid_o,
  output logic [NCH*SW-1:0]   smp_data_o
);
  initial begin
    smp_valid_o = 1'b0;
    smp_data_o  = '0;
  end
  // Outside a valid cycle the data is inverted, so a design that samples
  // without the valid flag sees a wrong value instead of a lucky stale one.
  task automatic send(input logic [SW-1:0] v);
    @(posedge core_clk_i);
    smp_valid_o <= 1'b1;
    smp_data_o  <= {NCH{v}};
    @(posedge core_clk_i);
    smp_valid_o <= 1'b0;
    smp_data_o  <= ~{NCH{v}};
  endtask
endmodule
`default_nettype wire

/* File: sampled_trigger_detector_bench.sv */
// Self-checking testbench for the sampled trigger detector.
`timescale 1ns/100ps
`default_nettype none
`include "sdt_map.svh"
module sampled_trigger_detector_bench;
  logic              clk = 1'b0;
  logic              rst;
  logic [5:0]        addr;
  logic [31:0]       wdata;
  logic              wr;
  logic              rd;
  logic              ms;
  logic [31:0]       rdata;
  logic              sv;
  logic              pw;
  logic              tw;
  logic [63:0]       sd;
  sdt_pkg::sdt_evt_t trig;
  int                fails = 0;
  int                num_checks = 0;
  int                n_start = 0;
  int                n_stop = 0;
  int                e_start = 0;
  int                e_stop = 0;
  int                ft [7] = '{10, 20, 50, 100, 200, 500, 1000};
  logic [15:0]       hit [2] = '{16'h00C8, 16'hFF38};

  always #2 clk = ~clk;

  sdt_smp_src src (.core_clk_i(clk), .smp_valid_o(sv), .smp_data_o(sd));
  sdt_trig_detect #(.SAMPLE_HZ(1000), .DEAD_CYC(8)) uut (
    .core_clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .smp_valid_i(sv),
    .smp_data_i(sd), .meas_start_i(ms), .trig_o(trig), .pre_wait_o(pw),
    .trig_wait_o(tw));

  // Counting pulses keeps the checks independent of the exact trigger latency.
  always @(posedge clk) begin
    if (trig.start === 1'b1) n_start <= n_start + 1;
    if (trig.stop === 1'b1) n_stop <= n_stop + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wreg(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [5:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic ck_start;
    settle;
    chk(n_start, e_start);
  endtask

  // The stop level register doubles as the upper bound value passed in up.
  task automatic arm(input logic [31:0] ctrl, input logic [31:0] cfg, input logic [15:0] lvl,
                     input logic [15:0] up, input logic [15:0] lo, input logic [31:0] pre);
    wreg(`SDT_A_CTRL, ctrl);
    wreg({`SDT_CH_BASE, `SDT_O_CFG}, cfg);
    wreg({`SDT_CH_BASE, `SDT_O_LVL}, {16'h0, lvl});
    wreg({`SDT_CH_BASE, `SDT_O_UP}, {16'h0, up});
    wreg({`SDT_CH_BASE, `SDT_O_LO}, {16'h0, lo});
    wreg({`SDT_CH_BASE, `SDT_O_SLVL}, {16'h0, up});
    wreg(`SDT_A_PRE, pre);
    @(posedge clk);
    ms <= 1'b1;
    @(posedge clk);
    ms <= 1'b0;
    #1;
  endtask

  task automatic t_regs;
    rreg(`SDT_A_CTRL, 32'h0);
    rreg(`SDT_A_STAT, 32'h0);
    wreg(`SDT_A_PRE, 32'h0000_0005);
    rreg(`SDT_A_PRE, 32'h0000_0005);
    @(posedge clk);
    #1;
    chk(rdata, 32'h0);
    wreg(6'h3F, 32'hFFFF_FFFF);
    rreg(6'h3F, 32'h0);
    rreg({`SDT_CH_BASE, `SDT_O_CFG}, 32'h0);
    $display("t_regs finished");
  endtask

  task automatic t_rise;
    arm(32'h1, 32'h1, 16'h0064, 16'h0000, 16'h0000, 32'h3);
    chk(pw, 1'b1);
    src.send(16'h0000);
    src.send(16'h00C8);
    src.send(16'h00C8);
    ck_start;
    chk({pw, tw}, 2'b01);
    src.send(16'h00C8);
    src.send(16'h0000);
    ck_start;
    src.send(16'h00C8);
    e_start++;
    ck_start;
    rreg(`SDT_A_STAT, 32'h0000_000D);
    chk(tw, 1'b0);
    $display("t_rise finished");
  endtask

  task automatic t_fall;
    arm(32'h1, 32'h9, 16'h0064, 16'h0000, 16'h0000, 32'h0);
    src.send(16'h0000);
    src.send(16'h00C8);
    ck_start;
    src.send(16'h0000);
    e_start++;
    ck_start;
    $display("t_fall finished");
  endtask

  task automatic t_and;
    for (int s = 0; s < 2; s++) begin
      arm(32'h5, {28'h0, s[0], 3'h1}, 16'h0064, 16'h0000, 16'h0000, 32'h0);
      src.send(hit[s]);
      e_start++;
      ck_start;
      arm(32'h5, {28'h0, s[0], 3'h1}, 16'h0064, 16'h0000, 16'h0000, 32'h0);
      src.send(16'h0064);
      src.send(hit[1-s]);
      ck_start;
    end
    $display("t_and finished");
  endtask

  task automatic t_win;
    arm(32'h1, 32'h2, 16'h0000, 16'h0064, 16'hFF9C, 32'h0);
    src.send(16'h0000);
    src.send(16'h00C8);
    ck_start;
    src.send(16'h0000);
    e_start++;
    ck_start;
    arm(32'h1, 32'h3, 16'h0000, 16'h0064, 16'hFF9C, 32'h0);
    src.send(16'h00C8);
    src.send(16'h0000);
    ck_start;
    src.send(16'hFF38);
    e_start++;
    ck_start;
    $display("t_win finished");
  endtask

  task automatic t_filt;
    for (int i = 0; i < 7; i++) begin
      arm({23'h0, 3'(i + 1), 6'h01}, 32'h1, 16'h0064, 16'h0000, 16'h0000, 32'h0);
      src.send(16'h0000);
      repeat (ft[i] - 1) src.send(16'h00C8);
      src.send(16'h0000);
      repeat (ft[i] - 1) src.send(16'h00C8);
      ck_start;
      src.send(16'h00C8);
      e_start++;
      ck_start;
    end
    $display("t_filt finished");
  endtask

  task automatic t_rt;
    for (int i = 0; i < 2; i++) begin
      wreg(`SDT_A_IVL, (i == 0) ? 32'h0000_2710 : 32'h0000_03E8);
      arm(32'h203, 32'h1, 16'h0064, 16'h0000, 16'h0000, 32'h0);
      src.send(16'h0000);
      repeat ((i == 0) ? 1 : 9) src.send(16'h00C8);
      ck_start;
      src.send(16'h00C8);
      e_start++;
      ck_start;
    end
    $display("t_rt finished");
  endtask

  task automatic t_dead;
    wreg(`SDT_A_IVL, 32'h0000_0001);
    arm(32'h13, 32'h11, 16'h0064, 16'h01F4, 16'h0000, 32'h0);
    src.send(16'h0000);
    src.send(16'h00C8);
    src.send(16'h0000);
    src.send(16'h0258);
    e_start++;
    ck_start;
    chk(n_stop, e_stop);
    repeat (12) @(posedge clk);
    src.send(16'h0000);
    src.send(16'h00C8);
    settle;
    chk(n_stop, e_stop);
    src.send(16'h0258);
    e_stop++;
    settle;
    chk(n_stop, e_stop);
    $display("t_dead finished");
  endtask

  // Drop needs half a mains cycle of low samples: 8 at 60 Hz, 10 at 50 Hz for 1000 samples/s.
  // The level 2000 is clamped to ten times the range of 50, so 600 is not a low sample.
  task automatic t_drop;
    wreg({`SDT_CH_BASE, `SDT_O_VRNG}, 32'h0000_0032);
    for (int f = 0; f < 3; f++) begin
      arm({26'h0, f[0], 5'h01}, (f == 2) ? 32'h4 : 32'h104, 16'h07D0, 16'h0, 16'h0, 32'h0);
      src.send(16'h0258);
      repeat ((f == 0) ? 7 : 9) src.send(16'h0190);
      src.send(16'h0258);
      repeat ((f == 0) ? 7 : 9) src.send(16'h0190);
      ck_start;
      src.send(16'h0190);
      if (f < 2) e_start++;
      ck_start;
    end
    for (int r = 0; r < 2; r++) begin
      arm({30'h0, r[0], 1'b1}, 32'h105, 16'h0, 16'h0064, 16'hFF9C, 32'h0);
      src.send(16'h0000);
      src.send(16'h00C8);
      if (r == 0) e_start++;
      ck_start;
    end
    $display("t_drop finished");
  endtask

  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    rst <= 1'b1;
    addr <= 6'h00;
    wdata <= 32'h0000_0000;
    wr <= 1'b0;
    rd <= 1'b0;
    ms <= 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_rise;
    t_fall;
    t_and;
    t_win;
    t_filt;
    t_rt;
    t_dead;
    t_drop;
    report_and_stop;
  end

  // The whole sequence needs about 8,300 cycles; this leaves ample margin.
  initial begin
    #200000;
    fails++;
    report_and_stop;
  end
endmodule
`default_nettype wire
